// ### design/reset_startup_pkg.sv
// Constants for the reset start-up and cause-flag logic.
// Assumes a 200 MHz system clock and a byte-wide register port with a 12-bit address.
package reset_startup_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ             = 200_000_000;
  localparam int unsigned POWER_UP_DELAY_TIMER_MAX_MS        = 64;
  // Longest time rounds down to whole cycles
  localparam int unsigned POWER_UP_DELAY_TIMER_MAX_CYCLES    = POWER_UP_DELAY_TIMER_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned START_DELAY_CYCLES = 10;

  // Register offsets
  localparam logic [11:0] BROWNOUT_CONTROL_OFS  = 12'h811;
  localparam logic [11:0] POWER_FLAGS_MAIN_OFS  = 12'h813;
  localparam logic [11:0] POWER_FLAGS_EXTRA_OFS = 12'h814;

  // Field positions
  localparam int unsigned SOFT_BOR_EN_BIT = 7;
  localparam int unsigned BOR_READY_BIT   = 0;
  localparam int unsigned STACK_OVER_BIT  = 7;
  localparam int unsigned STACK_UNDER_BIT = 6;
  localparam int unsigned WDT_FLAG_BIT    = 4;
  localparam int unsigned PIN_FLAG_BIT    = 3;
  localparam int unsigned RI_FLAG_BIT     = 2;
  localparam int unsigned POR_FLAG_BIT    = 1;
  localparam int unsigned BOR_FLAG_BIT    = 0;
  localparam int unsigned EXEC_VIOL_BIT   = 1;

  // Reset values and masks
  localparam logic [7:0] MAIN_FLAGS_POR   = 8'h3c;
  localparam logic [7:0] MAIN_FLAGS_MASK  = 8'hdf;
  localparam logic [7:0] EXTRA_FLAGS_POR  = 8'h02;
  localparam logic [7:0] EXTRA_FLAGS_MASK = 8'h02;
  localparam logic [14:0] IRQ_VECTOR      = 15'h0004;

  // Brown-out mode configuration
  typedef enum logic [1:0] {
    BOR_OFF      = 2'b00,
    BOR_SOFTWARE = 2'b01,
    BOR_NO_SLEEP = 2'b10,
    BOR_ALWAYS   = 2'b11
  } bor_mode_t;

  // Start-up sequencer states
  typedef enum logic [2:0] {
    ST_HOLD     = 3'b000,
    ST_POWER_UP_DELAY_TIMER     = 3'b001,
    ST_WAIT_PIN = 3'b010,
    ST_START    = 3'b011,
    ST_RUN      = 3'b100
  } seq_state_t;

endpackage

// ### design/reset_startup_and_cause_flags.sv
// Reset start-up sequencer, reset-cause flags and brown-out control register.
// Assumes core, supply monitor and pin inputs are synchronous to i_clk_sys; i_rst is the power-on reset.
`timescale 1ns/10ps
module reset_startup_and_cause_flags
  import reset_startup_pkg::*;
#(
  parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES = reset_startup_pkg::POWER_UP_DELAY_TIMER_MAX_CYCLES,
  parameter int unsigned PROG_WORDS  = 4096,
  parameter int unsigned SAF_WORDS   = 128,
  parameter int unsigned ADDR_W      = 15
)(
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  input  wire logic [11:0]       i_reg_addr,
  input  wire logic [7:0]        i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic      [7:0]        o_reg_rdata,
  input  wire logic [1:0]        i_power_up_delay_select,
  input  wire logic [1:0]        i_brownout_mode_cfg,
  input  wire logic              i_brownout_trip,
  input  wire logic              i_brownout_circuit_ok,
  input  wire logic              i_external_reset_pin_n,
  input  wire logic              i_external_reset_pin_en,
  input  wire logic              i_sleeping,
  input  wire logic              i_watchdog_overflow,
  input  wire logic              i_irq_wake,
  input  wire logic              i_global_irq_enable,
  input  wire logic              i_reset_instr,
  input  wire logic              i_stack_over,
  input  wire logic              i_stack_under,
  input  wire logic              i_stack_fault_reset_en,
  input  wire logic              i_fetch_valid,
  input  wire logic [ADDR_W-1:0] i_fetch_addr,
  input  wire logic              i_protected_storage_en,
  output logic                   o_core_run,
  output logic                   o_pc_zero,
  output logic                   o_resume_next,
  output logic                   o_take_vector,
  output logic      [ADDR_W-1:0] o_vector_addr,
  output logic                   o_timeout_status,
  output logic                   o_powerdown_status,
  output logic                   o_brownout_active
);
  import reset_startup_pkg::*;

  // Refuse parameters that the 24-bit counter, the fetch decode or the vector width cannot serve
  if (POWER_UP_DELAY_TIMER_CYCLES < 4 || POWER_UP_DELAY_TIMER_CYCLES >= (1 << 24) || PROG_WORDS > (1 << ADDR_W) || SAF_WORDS > PROG_WORDS
      || ADDR_W < 3 || ADDR_W > 15)
  begin : g_param_check
    $error("reset_startup_and_cause_flags: unsupported parameter values");
  end

  seq_state_t  state_q, state_d;
  logic [23:0] cnt_q, cnt_d;
  logic [7:0]  main_q, main_d;
  logic [7:0]  extra_q, extra_d;
  logic        sbe_q, sbe_d;
  logic        to_q, to_d;
  logic        pd_q, pd_d;
  logic        resume_q, vector_q;
  logic [7:0]  rdata_q;

  // Brown-out protection on/off per mode
  // mode gates soft enable
  wire bor_mode_t mode       = bor_mode_t'(i_brownout_mode_cfg);
  wire logic      bor_on     = (mode == BOR_ALWAYS) || (mode == BOR_NO_SLEEP && !i_sleeping)
                               || (mode == BOR_SOFTWARE && sbe_q);
  wire logic      bor_ready  = bor_on && i_brownout_circuit_ok;
  wire logic      bor_evt    = bor_on && i_brownout_trip;
  wire logic      ready_gate = (mode == BOR_ALWAYS || mode == BOR_NO_SLEEP) ? i_brownout_circuit_ok : 1'b1;

  // Power-up delay length from the select bits
  // limit from select bits
  wire logic [23:0] power_up_delay_timer_full = 24'(POWER_UP_DELAY_TIMER_CYCLES);
  wire logic [23:0] power_up_delay_timer_limit = (i_power_up_delay_select == 2'b11) ? power_up_delay_timer_full :
                                 (i_power_up_delay_select == 2'b10) ? {1'b0, power_up_delay_timer_full[23:1]} :
                                 {2'b00, power_up_delay_timer_full[23:2]};
  wire logic        power_up_delay_timer_sel   = (i_power_up_delay_select != 2'b00);
  wire logic        pin_low    = i_external_reset_pin_en && !i_external_reset_pin_n;
  wire logic        running    = (state_q == ST_RUN);

  wire logic fetch_bad = i_fetch_valid && ((32'(i_fetch_addr) >= PROG_WORDS)
                         || (i_protected_storage_en && 32'(i_fetch_addr) >= PROG_WORDS - SAF_WORDS));

  // Reset causes and wakes seen while running, in priority order
  wire logic ev_pin   = running && pin_low;
  wire logic ev_wdt   = running && !ev_pin && i_watchdog_overflow && !i_sleeping;
  wire logic ev_wwake = running && !ev_pin && i_watchdog_overflow && i_sleeping;
  wire logic ev_over  = running && !ev_pin && !i_watchdog_overflow && i_stack_over && i_stack_fault_reset_en;
  wire logic ev_under = running && !ev_pin && !i_watchdog_overflow && !ev_over
                        && i_stack_under && i_stack_fault_reset_en;
  wire logic ev_ri    = running && !ev_pin && !i_watchdog_overflow && !ev_over && !ev_under && i_reset_instr;
  wire logic ev_viol  = running && !ev_pin && !i_watchdog_overflow && !ev_over && !ev_under
                        && !i_reset_instr && fetch_bad;
  wire logic ev_iwake = running && !ev_pin && !i_watchdog_overflow && i_sleeping && i_irq_wake;
  wire logic soft_rst = ev_wdt || ev_over || ev_under || ev_ri || ev_viol;

  // Register decode
  // flag writes never reset
  wire logic wr_ctl   = i_reg_wr && (i_reg_addr == BROWNOUT_CONTROL_OFS);
  wire logic wr_main  = i_reg_wr && (i_reg_addr == POWER_FLAGS_MAIN_OFS);
  wire logic wr_extra = i_reg_wr && (i_reg_addr == POWER_FLAGS_EXTRA_OFS);
  wire logic [7:0] ctl_rd = {sbe_q, 6'h00, bor_ready};
  wire logic [7:0] rd_mux = (i_reg_addr == BROWNOUT_CONTROL_OFS)  ? ctl_rd :
                            (i_reg_addr == POWER_FLAGS_MAIN_OFS)  ? (main_q & MAIN_FLAGS_MASK) :
                            (i_reg_addr == POWER_FLAGS_EXTRA_OFS) ? (extra_q & EXTRA_FLAGS_MASK) : 8'h00;

  // Start-up sequencer next state
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q + 24'h000001;
    if (bor_evt)
      state_d = ST_HOLD;
    else
    begin
      unique case (state_q)
        ST_HOLD:
          if (!i_brownout_trip && ready_gate)
            state_d = power_up_delay_timer_sel ? ST_POWER_UP_DELAY_TIMER : ST_WAIT_PIN;
        ST_POWER_UP_DELAY_TIMER:
          if (cnt_q >= power_up_delay_timer_limit - 24'h000001)
            state_d = ST_WAIT_PIN;
        ST_WAIT_PIN:
          if (!pin_low)
            state_d = ST_START;
        ST_START:
          if (pin_low)
            state_d = ST_WAIT_PIN;
          else if (cnt_q == 24'(START_DELAY_CYCLES - 1))
            state_d = ST_RUN;
        ST_RUN:
          if (ev_pin)
            state_d = ST_WAIT_PIN;
          else if (soft_rst)
            state_d = ST_START;
        default:
          state_d = ST_HOLD;
      endcase
    end
    if (state_d != state_q)
      cnt_d = 24'h000000;
  end

  // Cause flags and status bits
  always_comb
  begin
    main_d  = wr_main ? (i_reg_wdata & MAIN_FLAGS_MASK) : main_q;
    extra_d = wr_extra ? (i_reg_wdata & EXTRA_FLAGS_MASK) : extra_q;
    sbe_d   = wr_ctl ? i_reg_wdata[SOFT_BOR_EN_BIT] : sbe_q;
    to_d    = to_q;
    pd_d    = pd_q;
    // brown-out reloads the main flags, an awake pin reset also sets the violation flag, else only the source's own flag; hardware beats a same-cycle write
    if (bor_evt)
    begin
      main_d = {2'b00, 1'b0, 3'b111, main_q[POR_FLAG_BIT], 1'b0};
      to_d   = 1'b1;
      pd_d   = 1'b1;
      sbe_d  = 1'b1;
    end
    else if (ev_pin)
    begin
      main_d[PIN_FLAG_BIT] = 1'b0;
      if (i_sleeping)
      begin
        to_d = 1'b1;
        pd_d = 1'b0;
      end
      else
        extra_d[EXEC_VIOL_BIT] = 1'b1;
    end
    else if (ev_wdt)
    begin
      main_d[WDT_FLAG_BIT] = 1'b0;
      to_d = 1'b0;
    end
    else if (ev_wwake)
    begin
      to_d = 1'b0;
      pd_d = 1'b0;
    end
    else if (ev_over)
      main_d[STACK_OVER_BIT] = 1'b1;
    else if (ev_under)
      main_d[STACK_UNDER_BIT] = 1'b1;
    else if (ev_ri)
      main_d[RI_FLAG_BIT] = 1'b0;
    else if (ev_viol)
      extra_d[EXEC_VIOL_BIT] = 1'b0;
    else if (ev_iwake)
    begin
      to_d = 1'b1;
      pd_d = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state_q <= ST_HOLD;
      cnt_q   <= 24'h000000;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Flag and status registers
  // power-on values
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      main_q  <= MAIN_FLAGS_POR;
      extra_q <= EXTRA_FLAGS_POR;
      sbe_q   <= 1'b1;
      to_q    <= 1'b1;
      pd_q    <= 1'b1;
    end
    else
    begin
      main_q  <= main_d;
      extra_q <= extra_d;
      sbe_q   <= sbe_d;
      to_q    <= to_d;
      pd_q    <= pd_d;
    end
  end

  // Wake pulses and read data
  // vector after next instruction
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      resume_q <= 1'b0;
      vector_q <= 1'b0;
      rdata_q  <= 8'h00;
    end
    else
    begin
      resume_q <= ev_wwake || ev_iwake;
      vector_q <= ev_iwake && i_global_irq_enable;
      rdata_q  <= i_reg_rd ? rd_mux : 8'h00;
    end
  end

  // Outputs
  // core held until run state
  assign o_core_run         = running;
  // program counter zero during any reset
  assign o_pc_zero          = !running;
  assign o_resume_next      = resume_q;
  assign o_take_vector      = vector_q;
  assign o_vector_addr      = IRQ_VECTOR[ADDR_W-1:0];
  assign o_timeout_status   = to_q;
  assign o_powerdown_status = pd_q;
  assign o_brownout_active  = bor_on;
  assign o_reg_rdata        = rdata_q;

  // Checks
  a_power_up_delay_timer_bounded: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state_q == ST_POWER_UP_DELAY_TIMER |-> cnt_q < power_up_delay_timer_full) else $error("power-up delay ran past its limit");
  a_hold_power_up_delay_timer: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state_q == ST_POWER_UP_DELAY_TIMER |-> !o_core_run && o_pc_zero) else $error("core ran during power-up delay");
  a_power_up_delay_timer_entry: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(state_q == ST_POWER_UP_DELAY_TIMER) |-> $past(!i_brownout_trip && power_up_delay_timer_sel)) else $error("delay began under reset");
  a_pin_blocks_run: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    pin_low |=> !o_core_run) else $error("ran with reset pin low");
  a_power_up_delay_timer_ignores_pin: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state_q == ST_POWER_UP_DELAY_TIMER && !bor_evt && cnt_q < power_up_delay_timer_limit - 24'h000001 |=> cnt_q == $past(cnt_q) + 24'h000001)
    else $error("delay stalled");
  a_start_ten: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(o_core_run) |-> $past(state_q, 10) == ST_START && $past(state_q, 11) != ST_START)
    else $error("start delay not ten cycles");
  a_viol_reset: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ev_viol && !bor_evt |=> !extra_q[EXEC_VIOL_BIT] && !o_core_run) else $error("violation not recorded");
  a_pin_awake: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ev_pin && !i_sleeping && !bor_evt |=> !main_q[PIN_FLAG_BIT] && extra_q[EXEC_VIOL_BIT] && $stable(main_q[4]))
    else $error("pin reset flags wrong");
  a_wdt_wake: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ev_wwake && !bor_evt |=> !o_timeout_status && !o_powerdown_status && o_resume_next && o_core_run)
    else $error("watchdog wake wrong");
  a_sw_no_reset: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    running && wr_main && !ev_pin && !soft_rst && !bor_evt |=> o_core_run) else $error("flag write reset core");
  a_sbe_por: assert property (@(posedge i_clk_sys)
    i_rst |=> sbe_q) else $error("soft brown-out enable not set");
  c_power_up_run: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(o_core_run));
  c_brownout: cover property (@(posedge i_clk_sys) disable iff (i_rst) bor_evt && running);
  c_irq_vector: cover property (@(posedge i_clk_sys) disable iff (i_rst) o_take_vector);
endmodule

// ### verification/supply_pin_model.sv
// Far-side model: external reset pin with pull-up and the supply monitor.
// Assumes the bench asks for pin holds and supply dips in step with i_clk_sys.
`timescale 1ns/10ps
module supply_pin_model #(
  parameter int unsigned WARM_CYCLES = 8
)(
  input  wire logic i_clk_sys,
  input  wire logic i_pin_hold,
  input  wire logic i_supply_low,
  output logic      o_pin_n,
  output logic      o_trip,
  output logic      o_circuit_ok
);
  logic [7:0] warm_q = 8'h00;

  // Weak pull-up: a released pin reads high
  assign o_pin_n = ~i_pin_hold;
  assign o_trip  = i_supply_low;

  // Monitor does not report circuit ok until it has warmed up after power-up
  always_ff @(posedge i_clk_sys)
  begin
    if (warm_q < 8'(WARM_CYCLES))
    begin
      warm_q <= warm_q + 8'h01;
    end
  end
  assign o_circuit_ok = (warm_q >= 8'(WARM_CYCLES));
endmodule

// ### verification/testbench.sv
// Self-checking bench for the reset start-up and cause-flag block.
// Assumes the supply/pin model on the far side and a 200 MHz system clock.
`timescale 1ns/10ps
module testbench;
  import reset_startup_pkg::*;
  localparam int unsigned POWER_UP_DELAY_TIMER = 40;
  logic        clk_sys, rst, reg_wr, reg_rd, pin_hold, supply_low, pin_en, sleeping, wdt, irq, global_irq_enable, ri;
  logic        over, under, stk_en, fetch_v, prot_en, pin_n, trip, circ_ok, core_run, pc_zero;
  logic        resume, take_vec, to_s, pd_s, bor_act;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rd_q;
  logic [1:0]  sel, mode;
  logic [14:0] fetch_addr, vec;
  int          err_count, checks, n;

  supply_pin_model i_supply_pin_model (.i_clk_sys(clk_sys), .i_pin_hold(pin_hold), .i_supply_low(supply_low),
    .o_pin_n(pin_n), .o_trip(trip), .o_circuit_ok(circ_ok));

  reset_startup_and_cause_flags #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER), .PROG_WORDS(4096), .SAF_WORDS(128))
  i_reset_startup_and_cause_flags (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_power_up_delay_select(sel), .i_brownout_mode_cfg(mode),
    .i_brownout_trip(trip), .i_brownout_circuit_ok(circ_ok), .i_external_reset_pin_n(pin_n),
    .i_external_reset_pin_en(pin_en), .i_sleeping(sleeping), .i_watchdog_overflow(wdt), .i_irq_wake(irq),
    .i_global_irq_enable(global_irq_enable), .i_reset_instr(ri), .i_stack_over(over), .i_stack_under(under),
    .i_stack_fault_reset_en(stk_en), .i_fetch_valid(fetch_v), .i_fetch_addr(fetch_addr),
    .i_protected_storage_en(prot_en), .o_core_run(core_run), .o_pc_zero(pc_zero), .o_resume_next(resume),
    .o_take_vector(take_vec), .o_vector_addr(vec), .o_timeout_status(to_s), .o_powerdown_status(pd_s),
    .o_brownout_active(bor_act));

  // 200 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t ns: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Counts and verdict, the only end of the run
  task automatic results();
    $display("Counts: %0d checks, %0d mismatches", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Register port: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] exp, input string msg);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp, msg);
  endtask

  // One-cycle event: 0 wdt, 1 irq, 2 reset instr, 3 over, 4 under, 5 fetch, 6 supply dip, 7 pin
  task automatic pulse(input int k);
    @(posedge clk_sys);
    case (k)
      0: wdt <= 1'b1;
      1: irq <= 1'b1;
      2: ri <= 1'b1;
      3: over <= 1'b1;
      4: under <= 1'b1;
      5: fetch_v <= 1'b1;
      6: supply_low <= 1'b1;
      default: pin_hold <= 1'b1;
    endcase
    @(posedge clk_sys);
    {wdt, irq, ri, over, under, fetch_v, supply_low} <= 7'h00;
    if (k == 7)
      pin_hold <= 1'b0;
    #1;
  endtask

  // Bounded wait for the core to run; counts edges
  task automatic wait_run(output int cnt);
    cnt = 0;
    while (core_run !== 1'b1 && cnt < 300)
    begin
      @(posedge clk_sys);
      #1 cnt++;
    end
    if (cnt >= 300)
    begin
      err_count++;
      $display("wrong value at %0t ns: core never started", $time);
      results();
    end
  endtask

  // A reset event, then the cause flags it leaves
  task automatic rst_ev(input int k, input logic [7:0] em, input logic [7:0] ex, input string m);
    pulse(k);
    chk(8'(core_run), 8'h00, m);
    wait_run(n);
    rchk(POWER_FLAGS_MAIN_OFS, em, m);
    rchk(POWER_FLAGS_EXTRA_OFS, ex, m);
  endtask

  // A wake from sleep: resume pulse, vector pulse, status bits
  task automatic wake(input int k, input logic v, input logic t, input string m);
    logic sr;
    logic sv;
    sr = 1'b0;
    sv = 1'b0;
    pulse(k);
    repeat (2)
    begin
      sr = sr | resume;
      sv = sv | take_vec;
      @(posedge clk_sys);
      #1;
    end
    chk({6'h00, sr, core_run}, 8'h03, m);
    chk({7'h00, sv}, {7'h00, v}, m);
    chk({6'h00, to_s, pd_s}, {6'h00, t, 1'b0}, m);
    rchk(POWER_FLAGS_MAIN_OFS, 8'hcb, m);
  endtask

  // Power-up with the pin held past the delay, then release
  task automatic t_startup();
    rchk(POWER_FLAGS_MAIN_OFS, 8'h1c, "main at power-on");
    rchk(POWER_FLAGS_EXTRA_OFS, 8'h02, "extra at power-on");
    rchk(BROWNOUT_CONTROL_OFS, 8'h81, "control at power-on");
    chk({6'h00, to_s, pd_s}, 8'h03, "status at power-on");
    repeat (POWER_UP_DELAY_TIMER + 20) @(posedge clk_sys);
    #1 chk({6'h00, core_run, pc_zero}, 8'h01, "held by pin");
    @(posedge clk_sys);
    pin_hold <= 1'b0;
    wait_run(n);
    // One edge samples the pin, then the start count
    chk(8'(n), 8'(START_DELAY_CYCLES + 1), "start delay");
    $display("test startup done");
  endtask

  // Software writes to flags, unmapped place, violation flag
  task automatic t_flags();
    wr(POWER_FLAGS_MAIN_OFS, 8'h00);
    #1 chk(8'(core_run), 8'h01, "write active no reset");
    rchk(POWER_FLAGS_MAIN_OFS, 8'h00, "main all active");
    wr(POWER_FLAGS_MAIN_OFS, 8'hff);
    rchk(POWER_FLAGS_MAIN_OFS, 8'hdf, "main written");
    wr(POWER_FLAGS_EXTRA_OFS, 8'h00);
    rchk(POWER_FLAGS_EXTRA_OFS, 8'h00, "extra written");
    wr(12'h812, 8'hff);
    rchk(12'h812, 8'h00, "unmapped read");
    rst_ev(7, 8'hd7, 8'h02, "pin reset awake");
    wr(POWER_FLAGS_MAIN_OFS, 8'h1f);
    rst_ev(0, 8'h0f, 8'h02, "watchdog reset");
    chk(8'(to_s), 8'h00, "timeout after watchdog");
    rst_ev(2, 8'h0b, 8'h02, "reset instruction");
    pulse(3);
    chk(8'(core_run), 8'h01, "stack reset disabled");
    @(posedge clk_sys);
    stk_en <= 1'b1;
    rst_ev(3, 8'h8b, 8'h02, "stack over");
    rst_ev(4, 8'hcb, 8'h02, "stack under");
    @(posedge clk_sys);
    fetch_addr <= 15'(4096);
    rst_ev(5, 8'hcb, 8'h00, "fetch beyond memory");
    wr(POWER_FLAGS_EXTRA_OFS, 8'h02);
    @(posedge clk_sys);
    prot_en    <= 1'b1;
    fetch_addr <= 15'(3967);
    pulse(5);
    chk(8'(core_run), 8'h01, "legal fetch");
    @(posedge clk_sys);
    fetch_addr <= 15'(3968);
    rst_ev(5, 8'hcb, 8'h00, "fetch protected area");
    $display("test flags done");
  endtask

  // Wakes from sleep and a pin reset in sleep
  task automatic t_sleep();
    @(posedge clk_sys);
    sleeping <= 1'b1;
    wake(0, 1'b0, 1'b0, "watchdog wake");
    wake(1, 1'b1, 1'b1, "irq wake enabled");
    chk(8'(vec === 15'h0004), 8'h01, "vector");
    @(posedge clk_sys);
    global_irq_enable <= 1'b0;
    wake(1, 1'b0, 1'b1, "irq wake disabled");
    rst_ev(7, 8'hc3, 8'h00, "pin reset asleep");
    chk({6'h00, to_s, pd_s}, 8'h02, "status after pin in sleep");
    @(posedge clk_sys);
    sleeping <= 1'b0;
    $display("test sleep done");
  endtask

  // Soft enable, brown-out resets and each delay select
  task automatic t_brownout();
    int lo;
    wr(BROWNOUT_CONTROL_OFS, 8'h00);
    rchk(BROWNOUT_CONTROL_OFS, 8'h01, "soft enable off");
    @(posedge clk_sys);
    mode <= 2'b01;
    @(posedge clk_sys);
    #1 chk(8'(bor_act), 8'h00, "software mode off");
    pulse(6);
    chk(8'(core_run), 8'h01, "dip ignored");
    wr(BROWNOUT_CONTROL_OFS, 8'h80);
    #1 chk(8'(bor_act), 8'h01, "software mode on");
    wr(BROWNOUT_CONTROL_OFS, 8'h00);
    mode <= 2'b11;
    @(posedge clk_sys);
    #1 chk(8'(bor_act), 8'h01, "always on");
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk_sys);
      sel <= 2'(s);
      pulse(6);
      wait_run(n);
      lo = (s == 0) ? 10 : 10 + (POWER_UP_DELAY_TIMER >> (3 - s));
      chk(8'(n >= lo && n <= lo + 4), 8'h01, "delay length");
    end
    rchk(POWER_FLAGS_MAIN_OFS, 8'h1e, "main after dip");
    rchk(POWER_FLAGS_EXTRA_OFS, 8'h00, "extra after dip");
    rchk(BROWNOUT_CONTROL_OFS, 8'h81, "soft enable set");
    chk({6'h00, to_s, pd_s}, 8'h03, "status after dip");
    @(posedge clk_sys);
    pin_en   <= 1'b0;
    pin_hold <= 1'b1;
    pulse(6);
    wait_run(n);
    chk(8'(core_run), 8'h01, "pin disabled");
    @(posedge clk_sys);
    pin_hold <= 1'b0;
    pin_en   <= 1'b1;
    mode     <= 2'b10;
    @(posedge clk_sys);
    #1 chk(8'(bor_act), 8'h01, "no-sleep mode awake");
    @(posedge clk_sys);
    sleeping <= 1'b1;
    @(posedge clk_sys);
    #1 chk(8'(bor_act), 8'h00, "no-sleep mode asleep");
    @(posedge clk_sys);
    sleeping <= 1'b0;
    mode     <= 2'b00;
    @(posedge clk_sys);
    #1 chk(8'(bor_act), 8'h00, "mode off");
    pulse(6);
    chk(8'(core_run), 8'h01, "dip ignored when off");
    $display("test brownout done");
  endtask

  // Main sequence
  initial
  begin
    {reg_wr, reg_rd, supply_low, sleeping, wdt, irq, ri, over, under, stk_en, fetch_v, prot_en} = 12'h000;
    rst        = 1'b1;
    pin_hold   = 1'b1;
    pin_en     = 1'b1;
    global_irq_enable        = 1'b1;
    sel        = 2'b11;
    mode       = 2'b11;
    reg_addr   = 12'h000;
    reg_wdata  = 8'h00;
    fetch_addr = 15'h0000;
    err_count  = 0;
    checks     = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_startup();
    t_flags();
    t_sleep();
    t_brownout();
    results();
  end
endmodule
